// file: core/alu_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_defs.svh"

module alu_core #(
  parameter int DEPTH = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    alu_pkg::flags_t flags;
    logic illegal;
    logic [6:0] faddr;
    logic [15:0] count;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [7:0] file_mem [DEPTH];

  // Memory write port, driven from the combinational block.
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_data;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Classifies an instruction word.
  function automatic alu_pkg::op_t decode(input logic [13:0] ins);
    alu_pkg::op_t op;
    op = alu_pkg::OP_NONE;
    if ((ins & `OPC_ADD_IMM_MASK) == `OPC_ADD_IMM_VAL) begin
      op = alu_pkg::OP_ADD_IMM;
    end else if ((ins & `OPC_AND_IMM_MASK) == `OPC_AND_IMM_VAL) begin
      op = alu_pkg::OP_AND_IMM;
    end else if ((ins & `OPC_FILE_MASK) == `OPC_ADD_FILE_VAL) begin
      op = alu_pkg::OP_ADD_FILE;
    end else if ((ins & `OPC_FILE_MASK) == `OPC_AND_FILE_VAL) begin
      op = alu_pkg::OP_AND_FILE;
    end
    return op;
  endfunction : decode

  // Adds two bytes and produces all three flags.
  function automatic alu_pkg::alu_res_t add8(input logic [7:0] a, input logic [7:0] b);
    alu_pkg::alu_res_t r;
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    r.value = full[7:0];
    r.flags.carry = full[8];
    r.flags.nibble_carry = lo[4];
    r.flags.zero = (full[7:0] == 8'h00);
    return r;
  endfunction : add8

  // Merges a 32-bit write into an old word under byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Handles the register bus and executes an instruction written to the
  // instruction register in the same cycle the write completes.
  always_comb begin
    alu_pkg::op_t op;
    alu_pkg::alu_res_t res;
    logic [13:0] ins;
    logic [7:0] fval;
    logic [6:0] fa;
    logic [31:0] wv;
    st_d = st_q;
    op = alu_pkg::OP_NONE;
    res = '0;
    ins = '0;
    fval = '0;
    fa = '0;
    wv = '0;
    mem_we = 1'b0;
    mem_addr = st_q.faddr;
    mem_data = 8'h00;

    // Capture write address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Perform the write once both halves are held.
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = 2'b00;
      unique case (st_q.aw_addr)
        `REG_INSTR: begin
          wv = merge(32'h0000_0000, st_q.w_data, st_q.w_strb);
          ins = wv[13:0];
          op = decode(ins);
          fa = ins[`FILE_ADDR_MSB:0];
          fval = file_mem[fa];
          st_d.illegal = (op == alu_pkg::OP_NONE);
          if (op != alu_pkg::OP_NONE) begin
            st_d.count = st_q.count + 16'h0001;
          end
          unique case (op)
            alu_pkg::OP_ADD_IMM: begin
              res = add8(st_q.acc, ins[`LIT_MSB:0]);
              st_d.acc = res.value;
              st_d.flags = res.flags;
            end
            alu_pkg::OP_AND_IMM: begin
              res.value = st_q.acc & ins[`LIT_MSB:0];
              st_d.acc = res.value;
              st_d.flags.zero = (res.value == 8'h00);
            end
            alu_pkg::OP_ADD_FILE, alu_pkg::OP_AND_FILE: begin
              if (op == alu_pkg::OP_ADD_FILE) begin
                res = add8(st_q.acc, fval);
                st_d.flags = res.flags;
              end else begin
                res.value = st_q.acc & fval;
                st_d.flags.zero = (res.value == 8'h00);
              end
              if (ins[`DEST_BIT]) begin
                mem_we = 1'b1;
                mem_addr = fa;
                mem_data = res.value;
              end else begin
                st_d.acc = res.value;
              end
            end
            default: begin
            end
          endcase
        end
        `REG_ACC: begin
          wv = merge({24'h000000, st_q.acc}, st_q.w_data, st_q.w_strb);
          st_d.acc = wv[7:0];
        end
        `REG_STATUS: begin
          wv = merge({24'h000000, 4'h0, st_q.illegal, st_q.flags}, st_q.w_data, st_q.w_strb);
          st_d.flags = wv[2:0];
          st_d.illegal = wv[`ST_ILLEGAL];
        end
        `REG_FADDR: begin
          wv = merge({25'h0000000, st_q.faddr}, st_q.w_data, st_q.w_strb);
          st_d.faddr = wv[6:0];
        end
        `REG_FDATA: begin
          wv = merge({24'h000000, file_mem[st_q.faddr]}, st_q.w_data, st_q.w_strb);
          mem_we = 1'b1;
          mem_data = wv[7:0];
        end
        `REG_COUNT: begin
          st_d.count = 16'h0000;
        end
        default: begin
          st_d.bresp = 2'b10;
        end
      endcase
    end

    // Read channel.
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = 2'b00;
      unique case (s_axi_araddr[7:0])
        `REG_INSTR: st_d.rdata = 32'h0000_0000;
        `REG_ACC: st_d.rdata = {24'h000000, st_q.acc};
        `REG_STATUS: st_d.rdata = {28'h0000000, st_q.illegal, st_q.flags};
        `REG_FADDR: st_d.rdata = {25'h0000000, st_q.faddr};
        `REG_FDATA: st_d.rdata = {24'h000000, file_mem[st_q.faddr]};
        `REG_COUNT: st_d.rdata = {16'h0000, st_q.count};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = 2'b10;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Handshake outputs
  // --------------------------------------------------------------------------
  // One write and one read are held at a time.
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rresp = st_q.rresp;
  assign s_axi_rdata = st_q.rdata;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Registers the whole state struct in one step; the file memory has its own block.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.acc <= `ACC_RESET;
      st_q.flags <= `FLAGS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Data-memory file; contents are undefined after reset.
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      file_mem[mem_addr] <= mem_data;
    end
  end

endmodule : alu_core
`default_nettype wire

// file: include/alu_defs.svh
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// --------------------------------------------------------------------------
// Opcode fields
// --------------------------------------------------------------------------
`define OPC_ADD_IMM_MASK 14'h3E00
`define OPC_ADD_IMM_VAL 14'h3E00
`define OPC_AND_IMM_MASK 14'h3F00
`define OPC_AND_IMM_VAL 14'h3900
`define OPC_FILE_MASK 14'h3F00
`define OPC_ADD_FILE_VAL 14'h0700
`define OPC_AND_FILE_VAL 14'h0500
`define DEST_BIT 7
`define FILE_ADDR_MSB 6
`define LIT_MSB 7

// --------------------------------------------------------------------------
// Register map offsets (byte addresses)
// --------------------------------------------------------------------------
`define REG_INSTR 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_FADDR 8'h0C
`define REG_FDATA 8'h10
`define REG_COUNT 8'h14

// --------------------------------------------------------------------------
// Status field positions and reset values
// --------------------------------------------------------------------------
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_ILLEGAL 3
`define ACC_RESET 8'h00
`define FLAGS_RESET 3'h0

`endif

// file: include/alu_pkg.sv
`default_nettype none
package alu_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE = 5'h01,
    OP_ADD_IMM = 5'h02,
    OP_AND_IMM = 5'h04,
    OP_ADD_FILE = 5'h08,
    OP_AND_FILE = 5'h10
  } op_t;

  // Flags carried together.
  typedef struct packed {
    logic zero;
    logic nibble_carry;
    logic carry;
  } flags_t;

  // ALU result and its flag outcome.
  typedef struct packed {
    logic [7:0] value;
    flags_t flags;
  } alu_res_t;

endpackage : alu_pkg
`default_nettype wire

// file: test/alu_core_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Register bus timing checker
// ------------------------------------------------
module alu_core_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write to any register is answered two edges after both halves are taken.
  b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write answer not on time.");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer not on time.");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("Write answer not released.");
  b_gap_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2])
    else $error("Spurious write answer.");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("Read answer not released.");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted while answer pending.");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read accepted while answer pending.");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("Refused read returned data.");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : alu_core_checker
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_defs.svh"
// ------------------------------------------------
// Bench top
// ------------------------------------------------
module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_errors = 0, num_checks = 0;
  // Free running 100 ns clock.
  always #50 aclk = ~aclk;
  alu_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      n_errors++;
    end
  endtask : chk
  // Write one word; inputs sampled mid-cycle and released after the taking edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int n;
    @(posedge aclk);
    awaddr <= {24'h0, a}; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    tb = 1'h0; n = 0;
    while (!tb && n < 40) begin
      @(negedge aclk);
      ta = awready; tw = wready; tb = bvalid; n++;
      if (tb) chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
    if (!tb) begin
      n_errors++;
      end_sim();
    end
  endtask : wr
  // Read one word and compare data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic ta, tr;
    int n;
    @(posedge aclk);
    araddr <= {24'h0, a}; arvalid <= 1'h1; rready <= 1'h1;
    tr = 1'h0; n = 0;
    while (!tr && n < 40) begin
      @(negedge aclk);
      ta = arready; tr = rvalid; n++;
      if (tr) chk(rdata, e);
      if (tr) chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end
    if (!tr) begin
      n_errors++;
      end_sim();
    end
  endtask : rd
  task automatic ex(input logic [13:0] i);
    wr(`REG_INSTR, {18'h0, i}, 2'h0);
  endtask : ex
  task automatic t_add_imm();
    wr(`REG_ACC, 32'h10, 2'h0); ex(14'h3E15);
    rd(`REG_ACC, 32'h25);
    rd(`REG_STATUS, 32'h0);
    wr(`REG_ACC, 32'h0F, 2'h0); ex(14'h3F01);
    rd(`REG_STATUS, 32'h2);
    wr(`REG_ACC, 32'hFF, 2'h0); ex(14'h3F01);
    rd(`REG_ACC, 32'h0);
    rd(`REG_STATUS, 32'h7);
  endtask : t_add_imm
  task automatic t_and_imm();
    wr(`REG_STATUS, 32'h3, 2'h0); wr(`REG_ACC, 32'hA3, 2'h0); ex(14'h395F);
    rd(`REG_ACC, 32'h03);
    rd(`REG_STATUS, 32'h3);
    ex(14'h3900);
    rd(`REG_STATUS, 32'h7);
  endtask : t_and_imm
  task automatic t_add_file();
    wr(`REG_FADDR, 32'h7F, 2'h0); wr(`REG_FDATA, 32'hC2, 2'h0); wr(`REG_ACC, 32'h17, 2'h0);
    ex(14'h077F);
    rd(`REG_ACC, 32'hD9);
    rd(`REG_FDATA, 32'hC2);
    rd(`REG_STATUS, 32'h0);
    ex(14'h07FF);
    rd(`REG_FDATA, 32'h9B);
    rd(`REG_ACC, 32'hD9);
    rd(`REG_STATUS, 32'h1);
  endtask : t_add_file
  task automatic t_and_file();
    wr(`REG_FADDR, 32'h0, 2'h0); wr(`REG_FDATA, 32'hC2, 2'h0); wr(`REG_ACC, 32'h17, 2'h0);
    wr(`REG_STATUS, 32'h3, 2'h0); ex(14'h0580);
    rd(`REG_FDATA, 32'h02);
    rd(`REG_ACC, 32'h17);
    rd(`REG_STATUS, 32'h3);
    wr(`REG_ACC, 32'h3C, 2'h0); ex(14'h0500);
    rd(`REG_ACC, 32'h0);
    rd(`REG_STATUS, 32'h7);
    rd(`REG_FDATA, 32'h02);
  endtask : t_and_file
  // Near-miss opcodes leave accumulator and flags alone and raise only the illegal bit.
  task automatic t_decode();
    wr(`REG_STATUS, 32'h0, 2'h0); wr(`REG_ACC, 32'h5A, 2'h0);
    ex(14'h38FF);
    rd(`REG_ACC, 32'h5A);
    rd(`REG_STATUS, 32'h8);
    ex(14'h06FF);
    rd(`REG_ACC, 32'h5A);
    rd(`REG_STATUS, 32'h8);
    ex(14'h3E00);
    rd(`REG_ACC, 32'h5A);
    rd(`REG_STATUS, 32'h0);
  endtask : t_decode
  // Every recognised instruction counts once in a single cycle; unrecognised words do not count.
  task automatic t_count();
    rd(`REG_COUNT, 32'h0A);
    wr(`REG_COUNT, 32'h0, 2'h0);
    rd(`REG_COUNT, 32'h0);
    ex(14'h3E01); ex(14'h3901); ex(14'h0000);
    rd(`REG_COUNT, 32'h2);
  endtask : t_count
  task automatic t_unmapped();
    wr(8'h18, 32'h5A, 2'h2);
    rd(8'h18, 32'h0, 2'h2);
  endtask : t_unmapped
  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_add_imm();
    t_and_imm();
    t_add_file();
    t_and_file();
    t_decode();
    t_count();
    t_unmapped();
    end_sim();
  end
endmodule : tb_top
bind alu_core alu_core_checker chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
